/* rtl/hsi_consts.vh */
/*
  Constants of the hub strap sampler: register byte offsets, field
  positions and reset values.
  Assumes it is included by bare name from the files under rtl/.
*/
`ifndef HSI_CONSTS_VH
`define HSI_CONSTS_VH

// Register byte offsets, one aligned 32-bit word each
`define HSI_OFS_STRAP      8'h00
`define HSI_OFS_CTRL       8'h04
`define HSI_OFS_OC_STATE   8'h08
`define HSI_OFS_IRQ_STAT   8'h0C
`define HSI_OFS_IRQ_MASK   8'h10

// Strap register fields
`define HSI_STRAP_SEL_LSB  0
`define HSI_STRAP_FIX_LSB  3
`define HSI_STRAP_POL_BIT  5
`define HSI_STRAP_VLD_BIT  6
`define HSI_STRAP_MASK_LSB 8

// Control register fields
`define HSI_CTRL_FIX_EN    0
`define HSI_CTRL_CONN      1
`define HSI_CTRL_HSPEED    2
`define HSI_CTRL_ACTIVE    3
`define HSI_CTRL_RST       4'h0

// Interrupt status and mask fields
`define HSI_IRQ_CAPT_BIT   0
`define HSI_IRQ_OC_LSB     1
`define HSI_IRQ_RST        8'h00

// Fixed-port strap encodings and decoded port masks
`define HSI_FIX_NONE       2'h0
`define HSI_FIX_P1         2'h1
`define HSI_FIX_P12        2'h2
`define HSI_FIX_P123       2'h3
`define HSI_MASK_NONE      3'h0
`define HSI_MASK_P1        3'h1
`define HSI_MASK_P12       3'h3
`define HSI_MASK_P123      3'h7

// Over-current filter reset level and pull-up enables
`define HSI_OC_IDLE        7'h7F
`define HSI_PULLUP_ON      7'h7F

`endif

/* rtl/hsi_sync3.v */
/*
  Three-stage input synchroniser with agreement filter.
  Assumes d_in is asynchronous to clk_sys; the filtered output changes
  only when the second and third stages agree.
*/
module hsi_sync3 #(
  parameter         W    = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock, reset and enable
  input  wire         clk_sys,
  input  wire         reset,
  input  wire         ce,
  // Raw and filtered levels
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  integer     i;

  //////////////////////////////////////////////////////////////////////
  // Stage chain; s1_ff feeds s2_ff only
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      q_out <= INIT;
    end else if (ce) begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // Bit follows only when the two late stages agree
      for (i = 0; i < W; i = i + 1) begin
        if (s2_ff[i] == s3_ff[i]) begin
          q_out[i] <= s3_ff[i];
        end
      end
    end
  end

endmodule // hsi_sync3

/* rtl/hsi_strap_top.v */
/*
  Hub strap sampler and indicator drivers with a classic Wishbone
  register slave and a level interrupt.
  Assumes strap resistors hold the shared pins stable while the hub
  reset pin is low and for a few clk_sys cycles after it rises, and
  that the current monitors drive the over-current inputs low on fault.
*/
// Overview of operation
// - The two-bit fixed-port strap decodes to none, port 1, ports 1-2 or ports 1-3 fixed.
// - Both fixed-port strap bits are captured at reset release only when the strap is enabled, else zero.
// - Configuration-select bit 0 on the serial clock pin is latched at the reset pin's rising edge.
// - Configuration-select bit 1 on the high-speed LED pin is latched at the same rising edge.
// - Latched select bit 1 at 0 makes the high-speed LED active high, at 1 active low.
// - The high-speed LED is asserted while connected at high speed and negated at full speed.
// - Seven active-low over-current inputs flag faults, each with an internal pull-up enabled.
// - Configuration-select bit 2 reads as constant zero in packages without its pin.
`include "hsi_consts.vh"

module hsi_strap_top #(
  parameter HAS_SEL2_PIN = 1
) (
  // Clock, reset and enable
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        ce,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Interrupt
  output reg         irq_o,
  // Hub reset pin, active low
  input  wire        hub_reset_n_pin,
  // Strap pins that are inputs here
  input  wire        cfg_method_sel_0,
  input  wire        cfg_method_sel_2,
  input  wire        fixed_port_strap_hi,
  // Shared LED pins
  input  wire        suspend_led_i,
  output reg         suspend_led_o,
  output reg         suspend_led_oe,
  input  wire        upstream_highspeed_led_i,
  output reg         upstream_highspeed_led_o,
  output reg         upstream_highspeed_led_oe,
  // Over-current sense
  input  wire [7:1]  overcurrent_sense_n,
  output reg  [7:1]  overcurrent_pullup_en,
  // Latched strap results
  output reg  [2:0]  cfg_method_sel,
  output reg  [1:0]  fixed_port_strap,
  output reg  [3:1]  fixed_port_mask,
  output reg         strap_valid
);

  //////////////////////////////////////////////////////////////////////
  // Declarations
  wire [4:0]  pin_filt;
  wire [7:1]  oc_filt_n;
  wire        rst_pin_filt;
  wire        sel0_filt;
  wire        sel1_filt;
  wire        sel2_filt;
  wire        fix_hi_filt;
  wire        fix_lo_filt;
  wire        rst_rise;
  wire        bus_req;
  wire        bus_wr;
  wire [2:0]  cap_sel;
  wire [1:0]  cap_fix;
  wire [7:0]  irq_event;
  wire        hs_assert;
  wire        drive_pins;
  reg         rst_prev_ff;
  reg  [7:1]  oc_prev_n_ff;
  reg  [3:0]  ctrl_ff;
  reg  [7:0]  irq_stat_ff;
  reg  [7:0]  irq_mask_ff;
  reg         hs_pol_ff;
  reg  [7:0]  nxt_irq_stat;
  reg  [31:0] nxt_dat;
  reg  [2:0]  nxt_mask;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Reset and strap pins but the suspend LED one share one filter so they age together
  hsi_sync3 #(
    .W    (5),
    .INIT (5'h00)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ce      (ce),
    .d_in    ({hub_reset_n_pin, cfg_method_sel_0,
               upstream_highspeed_led_i, cfg_method_sel_2,
               fixed_port_strap_hi}),
    .q_out   (pin_filt)
  );

  // Over-current inputs idle high
  hsi_sync3 #(
    .W    (7),
    .INIT (`HSI_OC_IDLE)
  ) u_oc_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ce      (ce),
    .d_in    (overcurrent_sense_n),
    .q_out   (oc_filt_n)
  );

  assign rst_pin_filt = pin_filt[4];
  assign sel0_filt    = pin_filt[3];
  assign sel1_filt    = pin_filt[2];
  assign fix_hi_filt  = pin_filt[0];

  assign sel2_filt = (HAS_SEL2_PIN != 0) ? pin_filt[1] : 1'b0;

  // Lower fixed-port strap shares the suspend LED pin
  hsi_sync3 #(
    .W    (1),
    .INIT (1'b0)
  ) u_susp_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ce      (ce),
    .d_in    (suspend_led_i),
    .q_out   (fix_lo_filt)
  );

  //////////////////////////////////////////////////////////////////////
  // Reset pin release detect
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rst_prev_ff <= 1'b0;
    end else if (ce) begin
      rst_prev_ff <= rst_pin_filt;
    end
  end

  // Filter resets low, so a pin already high when the block reset ends
  // counts as a release and takes a fresh capture
  assign rst_rise = rst_pin_filt & ~rst_prev_ff;

  assign cap_sel = {sel2_filt, sel1_filt, sel0_filt};

  assign cap_fix = ctrl_ff[`HSI_CTRL_FIX_EN] ?
                   {fix_hi_filt, fix_lo_filt} : `HSI_FIX_NONE;

  always @* begin
    case (cap_fix)
      `HSI_FIX_NONE: nxt_mask = `HSI_MASK_NONE;
      `HSI_FIX_P1:   nxt_mask = `HSI_MASK_P1;
      `HSI_FIX_P12:  nxt_mask = `HSI_MASK_P12;
      `HSI_FIX_P123: nxt_mask = `HSI_MASK_P123;
      default:       nxt_mask = `HSI_MASK_NONE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Strap latches
  // Cleared only by the block reset, never by the hub reset pin
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_method_sel   <= 3'h0;
      fixed_port_strap <= 2'h0;
      fixed_port_mask  <= 3'h0;
      hs_pol_ff        <= 1'b0;
      strap_valid      <= 1'b0;
    end else if (ce) begin
      // Load only at release, hold after
      if (rst_rise) begin
        cfg_method_sel   <= cap_sel;
        fixed_port_strap <= cap_fix;
        fixed_port_mask  <= nxt_mask;
        hs_pol_ff        <= sel1_filt;
        strap_valid      <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Indicator pins; released while the reset pin is low
  // The straps are read back through these pins, so the drivers stay
  // off until the filtered reset pin is high; a driven level reaches
  // the filter output only after the capture edge
  assign drive_pins = strap_valid & rst_pin_filt;

  assign hs_assert = ctrl_ff[`HSI_CTRL_CONN] & ctrl_ff[`HSI_CTRL_HSPEED];

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      upstream_highspeed_led_o  <= 1'b0;
      upstream_highspeed_led_oe <= 1'b0;
      suspend_led_o             <= 1'b0;
      suspend_led_oe            <= 1'b0;
      overcurrent_pullup_en     <= `HSI_PULLUP_ON;
    end else if (ce) begin
      upstream_highspeed_led_o  <= hs_assert ^ hs_pol_ff;
      upstream_highspeed_led_oe <= drive_pins;
      suspend_led_o             <= ctrl_ff[`HSI_CTRL_ACTIVE];
      suspend_led_oe            <= drive_pins;
      overcurrent_pullup_en     <= `HSI_PULLUP_ON;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Over-current fault edge detect
  // Reset value matches the idle level, so no fault edge follows reset
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      oc_prev_n_ff <= `HSI_OC_IDLE;
    end else if (ce) begin
      oc_prev_n_ff <= oc_filt_n;
    end
  end

  // Low level on a sense input is a fault
  assign irq_event = {(~oc_filt_n & oc_prev_n_ff), rst_rise};

  //////////////////////////////////////////////////////////////////////
  // Wishbone decode; one wait state, then ack for one cycle
  // Only byte lane 0 holds writable fields; a write with lane 0 off is dropped
  // A held strobe is masked while ack is high, so ack never stretches
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];

  // Read data mux; unmapped words read zero
  always @* begin
    nxt_dat = 32'h0000_0000;
    case (wb_adr_i)
      `HSI_OFS_STRAP: begin
        nxt_dat[`HSI_STRAP_SEL_LSB +: 3]  = cfg_method_sel;
        nxt_dat[`HSI_STRAP_FIX_LSB +: 2]  = fixed_port_strap;
        nxt_dat[`HSI_STRAP_POL_BIT]       = hs_pol_ff;
        nxt_dat[`HSI_STRAP_VLD_BIT]       = strap_valid;
        nxt_dat[`HSI_STRAP_MASK_LSB +: 3] = fixed_port_mask;
      end
      `HSI_OFS_CTRL: begin
        nxt_dat[3:0] = ctrl_ff;
      end
      `HSI_OFS_OC_STATE: begin
        nxt_dat[7:1] = ~oc_filt_n;
      end
      `HSI_OFS_IRQ_STAT: begin
        nxt_dat[7:0] = irq_stat_ff;
      end
      `HSI_OFS_IRQ_MASK: begin
        nxt_dat[7:0] = irq_mask_ff;
      end
      default: begin
        nxt_dat = 32'h0000_0000;
      end
    endcase
  end

  // Status update; a new event wins over a clear
  // The clear masks the old status and the events are ored in after it
  always @* begin
    nxt_irq_stat = irq_stat_ff;
    if (bus_wr && (wb_adr_i == `HSI_OFS_IRQ_STAT)) begin
      nxt_irq_stat = irq_stat_ff & ~wb_dat_i[7:0];
    end
    nxt_irq_stat = nxt_irq_stat | irq_event;
  end

  //////////////////////////////////////////////////////////////////////
  // Bus and register flops
  // Read data is loaded with ack and holds until the next request
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      ctrl_ff     <= `HSI_CTRL_RST;
      irq_stat_ff <= `HSI_IRQ_RST;
      irq_mask_ff <= `HSI_IRQ_RST;
      irq_o       <= 1'b0;
    end else if (ce) begin
      wb_ack_o    <= bus_req;
      irq_stat_ff <= nxt_irq_stat;
      irq_o       <= |(nxt_irq_stat & irq_mask_ff);
      if (bus_req) begin
        wb_dat_o <= nxt_dat;
      end
      if (bus_wr && (wb_adr_i == `HSI_OFS_CTRL)) begin
        ctrl_ff <= wb_dat_i[3:0];
      end
      if (bus_wr && (wb_adr_i == `HSI_OFS_IRQ_MASK)) begin
        irq_mask_ff <= wb_dat_i[7:0];
      end
    end
  end

endmodule // hsi_strap_top

/* dv/hsi_chk.sv */
/* Port checker for hsi_strap_top.
   Assumes strap pins hold 8 cycles after the hub pin rises. */
module hsi_chk #(
  parameter HAS_SEL2_PIN = 1
) (
  // Clock, reset, bus
  input wire       clk_sys,
  input wire       reset,
  input wire       ce,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o,
  // Pins
  input wire       hub_reset_n_pin,
  input wire       cfg_method_sel_0,
  input wire       cfg_method_sel_2,
  input wire       fixed_port_strap_hi,
  input wire       suspend_led_i,
  input wire       upstream_highspeed_led_i,
  input wire       upstream_highspeed_led_oe,
  input wire [7:1] overcurrent_pullup_en,
  // Latched straps
  input wire [2:0] cfg_method_sel,
  input wire [1:0] fixed_port_strap,
  input wire [3:1] fixed_port_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [3:0] hi_cnt_ff;
  wire       at8 = (hi_cnt_ff == 4'h8);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Cycles the hub reset pin has been high
  always @(posedge clk_sys or posedge reset)
    if (reset)
      hi_cnt_ff <= 4'h0;
    else if (!hub_reset_n_pin)
      hi_cnt_ff <= 4'h0;
    else if (hi_cnt_ff != 4'hF)
      hi_cnt_ff <= hi_cnt_ff + 4'h1;

  chk_mask_decode: assert property (
    fixed_port_mask == {&fixed_port_strap, fixed_port_strap[1],
                        |fixed_port_strap}) else $error("mask decode");
  chk_fix_capture: assert property (at8 |-> fixed_port_strap == 2'h0 ||
    fixed_port_strap == {fixed_port_strap_hi, $past(suspend_led_i, 6)})
    else $error("fixed strap");
  chk_sel0_latch: assert property (
    at8 |-> cfg_method_sel[0] == $past(cfg_method_sel_0, 6))
    else $error("sel0 latch");
  chk_sel1_latch: assert property (
    at8 |-> cfg_method_sel[1] == $past(upstream_highspeed_led_i, 6))
    else $error("sel1 latch");
  chk_sel2_latch: assert property (at8 |-> cfg_method_sel[2] ==
    (HAS_SEL2_PIN != 0 && $past(cfg_method_sel_2, 6)))
    else $error("sel2 latch");
  chk_strap_hold: assert property (
    !$stable({cfg_method_sel, fixed_port_strap}) |-> hi_cnt_ff < 4'hA)
    else $error("strap moved");
  chk_led_release: assert property (
    !hub_reset_n_pin [*8] |-> !upstream_highspeed_led_oe)
    else $error("led not released");
  chk_pullup_on: assert property (
    overcurrent_pullup_en == 7'h7F) else $error("pull-up off");
  chk_ack_answer: assert property (ce && wb_cyc_i && wb_stb_i &&
    !wb_ack_o |=> wb_ack_o) else $error("no ack");
  chk_ack_once: assert property (
    ce && wb_ack_o |=> !wb_ack_o) else $error("long ack");
endmodule // hsi_chk

bind hsi_strap_top hsi_chk #(.HAS_SEL2_PIN(HAS_SEL2_PIN)) u_chk (
  .clk_sys, .reset, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .hub_reset_n_pin,
  .cfg_method_sel_0, .cfg_method_sel_2, .fixed_port_strap_hi,
  .suspend_led_i, .upstream_highspeed_led_i, .upstream_highspeed_led_oe,
  .overcurrent_pullup_en, .cfg_method_sel, .fixed_port_strap,
  .fixed_port_mask
);

/* dv/hsi_partner.sv */
/* Far side: strap resistors, current monitors and LEDs.
   Assumes the bench sets strap levels and fault flags. */
module hsi_partner (
  // Design side
  input  wire       hs_oe,
  input  wire       hs_o,
  input  wire       su_oe,
  input  wire       su_o,
  input  wire [7:1] pu_en,
  // Board side
  input  wire       hs_strap,
  input  wire       su_strap,
  input  wire [7:1] fault,
  // Pin levels
  output wire       hs_pin,
  output wire       su_pin,
  output wire [7:1] oc_n
);
  timeunit 1ns;
  timeprecision 1ps;
  assign hs_pin = hs_oe ? hs_o : hs_strap;
  assign su_pin = su_oe ? su_o : su_strap;
  // monitor pulls low, pull-up holds high
  assign oc_n = ~fault & pu_en;
endmodule // hsi_partner

/* dv/hsi_tb.sv */
/* Testbench for hsi_strap_top with the far-side model.
   Assumes the checker is bound and ce stays high. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i;
  logic        hub_reset_n_pin, cfg_method_sel_0, cfg_method_sel_2;
  logic        fixed_port_strap_hi, hs_strap, su_strap;
  logic        ce = 1'b1;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, rd;
  logic [7:1]  fault;
  logic [2:0]  mtab [0:3] = '{3'h0, 3'h1, 3'h3, 3'h7};
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, irq_o, suspend_led_i, suspend_led_o;
  wire         suspend_led_oe, upstream_highspeed_led_i, strap_valid;
  wire         upstream_highspeed_led_o, upstream_highspeed_led_oe;
  wire  [7:1]  overcurrent_sense_n, overcurrent_pullup_en;
  wire  [2:0]  cfg_method_sel, cfg_sel_nopin;
  wire  [1:0]  fixed_port_strap;
  wire  [3:1]  fixed_port_mask;
  int          n_fail = 0;
  int          compares = 0;

  hsi_strap_top uut (
    .clk_sys, .reset, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .hub_reset_n_pin,
    .cfg_method_sel_0, .cfg_method_sel_2, .fixed_port_strap_hi,
    .suspend_led_i, .suspend_led_o, .suspend_led_oe,
    .upstream_highspeed_led_i, .upstream_highspeed_led_o,
    .upstream_highspeed_led_oe, .overcurrent_sense_n,
    .overcurrent_pullup_en, .cfg_method_sel, .fixed_port_strap,
    .fixed_port_mask, .strap_valid
  );
  // Second copy for a package without the select bit 2 pin
  hsi_strap_top #(.HAS_SEL2_PIN(0)) uut_nosel2 (
    .clk_sys, .reset, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o(), .wb_ack_o(), .irq_o(),
    .hub_reset_n_pin, .cfg_method_sel_0, .cfg_method_sel_2,
    .fixed_port_strap_hi, .suspend_led_i, .suspend_led_o(),
    .suspend_led_oe(), .upstream_highspeed_led_i,
    .upstream_highspeed_led_o(), .upstream_highspeed_led_oe(),
    .overcurrent_sense_n, .overcurrent_pullup_en(),
    .cfg_method_sel(cfg_sel_nopin), .fixed_port_strap(),
    .fixed_port_mask(), .strap_valid()
  );
  hsi_partner far (
    .hs_oe(upstream_highspeed_led_oe), .hs_o(upstream_highspeed_led_o),
    .su_oe(suspend_led_oe), .su_o(suspend_led_o), .hs_strap, .su_strap,
    .pu_en(overcurrent_pullup_en), .fault, .oc_n(overcurrent_sense_n),
    .hs_pin(upstream_highspeed_led_i), .su_pin(suspend_led_i)
  );

  ////////////////////////////////////////
  // Shared helpers
  task automatic tally_and_finish;
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One classic Wishbone cycle, read data left in rd
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk(n, 2);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Pulse the hub reset pin with straps {sel2, sel1, sel0, hi, lo}
  task automatic capture(input logic [4:0] s);
    hub_reset_n_pin <= 1'b0;
    {cfg_method_sel_2, hs_strap, cfg_method_sel_0} <= s[4:2];
    {fixed_port_strap_hi, su_strap} <= s[1:0];
    wt(10);
    hub_reset_n_pin <= 1'b1;
    wt(12);
  endtask

  // Every fixed-port code, each with one of four select patterns, then the LED
  task automatic t_straps;
    for (int i = 0; i < 4; i++) begin
      wb(1, 8'h04, 32'h1);
      capture({i[0] ^ i[1], i[0], i[1], i[1], i[0]});
      chk(fixed_port_mask, mtab[i]);
      chk(fixed_port_strap, i);
      chk(cfg_method_sel, {i[0] ^ i[1], i[0], i[1]});
      chk(cfg_sel_nopin, {1'b0, i[0], i[1]});
      wb(0, 8'h00, 0);
      chk(rd, {mtab[i], 2'b01, i[0], i[1:0], i[0] ^ i[1], i[0], i[1]});
      wb(1, 8'h04, 32'h7);
      wt(2);
      chk(upstream_highspeed_led_oe, 1);
      chk(upstream_highspeed_led_i, !i[0]);
      wb(1, 8'h04, 32'h3);
      wt(2);
      chk(upstream_highspeed_led_i, i[0]);
    end
  endtask
  // Disabled strap reads zero, latches hold while pins move
  task automatic t_hold;
    wb(1, 8'h04, 32'h0);
    wb(1, 8'h0C, 32'h01);
    capture(5'h1B);
    chk(fixed_port_strap, 0);
    wb(0, 8'h0C, 0);
    chk(rd[0], 1);
    cfg_method_sel_0 <= 1'b1;
    cfg_method_sel_2 <= 1'b0;
    hs_strap <= 1'b0;
    su_strap <= 1'b0;
    wt(20);
    chk(cfg_method_sel, 3'h6);
    chk(strap_valid, 1);
    wb(1, 8'h04, 32'h8);
    wt(2);
    chk({suspend_led_oe, suspend_led_i}, 2'b11);
  endtask
  // Fault sets sticky status; mask and clear steer the interrupt
  task automatic t_irq;
    wb(1, 8'h0C, 32'hFF);
    wb(1, 8'h10, 32'h08);
    fault <= 7'h04;
    wt(10);
    wb(0, 8'h08, 0);
    chk(rd, 32'h08);
    chk(irq_o, 1);
    fault <= 7'h10;
    wt(10);
    wb(0, 8'h0C, 0);
    chk(rd, 32'h28);
    wb(1, 8'h0C, 32'h08);
    wt(2);
    chk(irq_o, 0);
    wb(0, 8'h14, 0);
    chk(rd, 0);
    fault <= 7'h00;
  endtask

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Reset, then the scenarios
  initial begin
    reset = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {hub_reset_n_pin, cfg_method_sel_0, cfg_method_sel_2} = '0;
    {fixed_port_strap_hi, hs_strap, su_strap, fault} = '0;
    wt(4);
    reset <= 1'b0;
    t_straps;
    t_hold;
    t_irq;
    tally_and_finish;
  end
  // Watchdog
  initial begin
    #100000;
    n_fail++;
    tally_and_finish;
  end
endmodule // testbench
